// *** hw/dtd_thresholds.sv ***
`timescale 1ns/10ps
// What this block does
// (R1) Row detected when row/low total exceeds threshold
// (R2) Column detected against one shared threshold
// (R3) Low over high power within forward twist
// (R4) High over low power within reverse twist
// (R5) Peak row dominates other rows by threshold
// (R6) Peak column dominates other columns by threshold
// (R7) Peak row over its harmonic exceeds threshold
// (R8) Peak column over its harmonic exceeds threshold
// (R9) Total power below minimum ignores decision
// (R10) Two-step gain switches at hot limit
// (R11) All thresholds treated as signed
// (R12) Software programs thresholds after reset
// (R13) Software writes zeros to unused bits
// (R14) Data then address writes; address alone reads
// (R15) Service at 16 kHz, pending flag, done pulse
// (R16) Valid key needs one row, one column, all checks
module dtd_thresholds
  import dtd_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Indirect access ports
  input  wire logic              data_wr,
  input  wire logic [WORD_W-1:0] data_in,
  input  wire logic              addr_wr,
  input  wire logic [ADDR_W-1:0] addr_in,
  output logic      [WORD_W-1:0] indirect_data_port,
  output logic                   indirect_pending_flag,
  output logic                   indirect_done_interrupt,
  // Measured powers
  input  wire logic              meas_valid,
  input  wire dtd_meas_type      meas,
  // Decision results
  output logic                   result_valid,
  output logic      [3:0]        row_detect,
  output logic      [3:0]        col_detect,
  output dtd_checks_type         checks,
  output logic                   key_valid,
  output logic      [3:0]        key_code,
  output logic                   agc_step
);

  // Strongest entry of a group
  function automatic logic [1:0] dtd_peak(input dtd_pow4_type p);
    logic [1:0] idx;
    idx = 2'd0;
    for (int i = 1; i < 4; i++) begin
      if (p[i] > p[idx]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // Position of the set bit of a one-hot vector
  function automatic logic [1:0] dtd_pos(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  dtd_thr_array_type thr;               // Threshold image

  // Indirect store and its ports
  dtd_indirect u_ind (
    .clk       (clk),
    .srst      (srst),
    .data_wr   (data_wr),
    .data_in   (data_in),
    .addr_wr   (addr_wr),
    .addr_in   (addr_in),
    .data_port (indirect_data_port),
    .pending   (indirect_pending_flag),
    .done      (indirect_done_interrupt),
    .thr       (thr)
  );

  logic [SUM_W-1:0] row_ext [4];        // Widened row powers
  logic [SUM_W-1:0] col_ext [4];        // Widened column powers
  logic [SUM_W-1:0] row_total;          // Low band total
  logic [SUM_W-1:0] col_total;          // High band total
  logic [SUM_W:0]   all_total;          // Both bands
  logic [1:0]       row_peak;           // Strongest row
  logic [1:0]       col_peak;           // Strongest column
  logic [SUM_W-1:0] row_peak_pow;
  logic [SUM_W-1:0] col_peak_pow;
  logic [3:0]       row_peak_hot;       // Peak row one-hot
  logic [3:0]       col_peak_hot;       // Peak column one-hot
  logic [3:0]       row_pass;           // Row ratio passes
  logic [3:0]       col_pass;           // Column ratio passes
  logic [3:0]       row_dom_raw;        // Peak over each row
  logic [3:0]       col_dom_raw;        // Peak over each column
  logic             fwd_over;           // Low/high above limit
  logic             rev_over;           // High/low above limit
  logic             low_harm_ok;
  logic             high_harm_ok;
  logic             min_ok;             // Enough total power
  logic             hot;                // Above hot limit
  dtd_checks_type   chk;                // All checks this frame
  logic             all_ok;             // Every check passes
  logic             key_ok;             // Decision for this frame
  logic [3:0]       row_gated;          // Row flags after power gate
  logic [3:0]       col_gated;          // Column flags after power gate

  // Registered outputs
  logic             result_valid_reg;
  logic [3:0]       row_detect_reg;
  logic [3:0]       col_detect_reg;
  dtd_checks_type   checks_reg;
  logic             key_valid_reg;
  logic [3:0]       key_code_reg;
  logic             agc_step_reg;

  // Band sums
  assign row_total = row_ext[0] + row_ext[1] + row_ext[2] + row_ext[3];
  assign col_total = col_ext[0] + col_ext[1] + col_ext[2] + col_ext[3];
  assign all_total = (SUM_W + 1)'(row_total) + (SUM_W + 1)'(col_total);

  // Peak selection
  assign row_peak     = dtd_peak(meas.row_pow);
  assign col_peak     = dtd_peak(meas.col_pow);
  assign row_peak_pow = row_ext[row_peak];
  assign col_peak_pow = col_ext[col_peak];
  assign row_peak_hot = 4'h1 << row_peak;
  assign col_peak_hot = 4'h1 << col_peak;

  // Per-entry pass and dominance tests
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_band
      assign row_ext[g] = SUM_W'(meas.row_pow[g]);
      assign col_ext[g] = SUM_W'(meas.col_pow[g]);

      // Own threshold per row
      dtd_ratio_cmp #(.UNITY(PASS_UNITY)) u_row_pass (
        .num   (row_ext[g]),
        .den   (row_total),
        .thr   ($signed(thr[IDX_LOW_PASS_0 + g])),
        .above (row_pass[g])                                       // see (R1)
      );

      // Shared threshold for all columns
      dtd_ratio_cmp #(.UNITY(PASS_UNITY)) u_col_pass (
        .num   (col_ext[g]),
        .den   (col_total),
        .thr   ($signed(thr[IDX_HIGH_PASS])),
        .above (col_pass[g])                                       // see (R2)
      );

      // Peak row against this row
      dtd_ratio_cmp #(.UNITY(REL_UNITY)) u_row_dom (
        .num   (row_peak_pow),
        .den   (row_ext[g]),
        .thr   ($signed(thr[IDX_LOW_DOM])),
        .above (row_dom_raw[g])                                    // see (R5)
      );

      // Peak column against this column
      dtd_ratio_cmp #(.UNITY(REL_UNITY)) u_col_dom (
        .num   (col_peak_pow),
        .den   (col_ext[g]),
        .thr   ($signed(thr[IDX_HIGH_DOM])),
        .above (col_dom_raw[g])                                    // see (R6)
      );
    end
  endgenerate

  // Forward twist: peak row over peak column
  dtd_ratio_cmp #(.UNITY(REL_UNITY)) u_fwd (
    .num   (row_peak_pow),
    .den   (col_peak_pow),
    .thr   ($signed(thr[IDX_FWD_TWIST])),
    .above (fwd_over)                                              // see (R3)
  );

  // Reverse twist: peak column over peak row
  dtd_ratio_cmp #(.UNITY(REL_UNITY)) u_rev (
    .num   (col_peak_pow),
    .den   (row_peak_pow),
    .thr   ($signed(thr[IDX_REV_TWIST])),
    .above (rev_over)                                              // see (R4)
  );

  // Peak row against its second harmonic
  dtd_ratio_cmp #(.UNITY(REL_UNITY)) u_row_harm (
    .num   (row_peak_pow),
    .den   (SUM_W'(meas.row_harm)),
    .thr   ($signed(thr[IDX_LOW_HARM])),
    .above (low_harm_ok)                                           // see (R7)
  );

  // Peak column against its second harmonic
  dtd_ratio_cmp #(.UNITY(REL_UNITY)) u_col_harm (
    .num   (col_peak_pow),
    .den   (SUM_W'(meas.col_harm)),
    .thr   ($signed(thr[IDX_HIGH_HARM])),
    .above (high_harm_ok)                                          // see (R8)
  );

  // Signed power gates; a negative limit never blocks
  assign min_ok = $signed({1'b0, all_total})
                  >= $signed(thr[IDX_MIN_POWER]);                  // see (R9) (R11)
  assign hot    = $signed({1'b0, all_total})
                  > $signed(thr[IDX_AGC_HOT]);                     // see (R10)

  // Collected check flags
  assign chk.fwd_twist_ok = ~fwd_over;                             // see (R3)
  assign chk.rev_twist_ok = ~rev_over;                             // see (R4)
  assign chk.low_dom_ok   = &(row_dom_raw | row_peak_hot);         // see (R5)
  assign chk.high_dom_ok  = &(col_dom_raw | col_peak_hot);         // see (R6)
  assign chk.low_harm_ok  = low_harm_ok;
  assign chk.high_harm_ok = high_harm_ok;
  assign chk.min_power_ok = min_ok;

  // Final decision
  assign all_ok    = &chk;
  assign key_ok    = $onehot(row_pass) & $onehot(col_pass) & all_ok; // see (R16)
  assign row_gated = min_ok ? row_pass : 4'h0;                     // see (R9)
  assign col_gated = min_ok ? col_pass : 4'h0;                     // see (R9)

  // Result registers, updated once per measured frame
  always_ff @(posedge clk) begin
    if (srst) begin
      result_valid_reg <= 1'b0;
      row_detect_reg   <= 4'h0;
      col_detect_reg   <= 4'h0;
      checks_reg       <= '0;
      key_valid_reg    <= 1'b0;
      key_code_reg     <= 4'h0;
    end else begin
      result_valid_reg <= meas_valid;
      if (meas_valid) begin
        row_detect_reg <= row_gated;                               // see (R1) (R2)
        col_detect_reg <= col_gated;
        checks_reg     <= chk;
        key_valid_reg  <= key_ok;                                  // see (R16)
        key_code_reg   <= key_ok ? {dtd_pos(row_pass), dtd_pos(col_pass)}
                                 : 4'h0;
      end
    end
  end

  // Two-step gain: attenuated step while total is above hot limit
  always_ff @(posedge clk) begin
    if (srst) begin
      agc_step_reg <= 1'b0;
    end else if (meas_valid) begin
      agc_step_reg <= hot;                                         // see (R10)
    end
  end

  // Output drive
  assign result_valid = result_valid_reg;
  assign row_detect   = row_detect_reg;
  assign col_detect   = col_detect_reg;
  assign checks       = checks_reg;
  assign key_valid    = key_valid_reg;
  assign key_code     = key_code_reg;
  assign agc_step     = agc_step_reg;

  // Decision guards; frames may arrive back to back
  a_key_one_each: assert property (@(posedge clk) disable iff (srst) // see (R16)
    key_valid_reg |-> $onehot(row_detect_reg) && $onehot(col_detect_reg) && (&checks_reg))
    else $error("key reported without one row and column");
  a_min_gate_blocks: assert property (@(posedge clk) disable iff (srst) // see (R9)
    meas_valid && !min_ok |=> !key_valid_reg && row_detect_reg == 4'h0 && col_detect_reg == 4'h0)
    else $error("low power frame produced a detection");
  a_result_timing: assert property (@(posedge clk) disable iff (srst) // see (R16)
    meas_valid |=> result_valid_reg ##1 (result_valid_reg == $past(meas_valid)))
    else $error("result strobe timing wrong");
  a_row_pass_kept: assert property (@(posedge clk) disable iff (srst) // see (R1)
    meas_valid && min_ok |=> row_detect_reg == $past(row_pass))
    else $error("row detect does not follow ratio test");
  a_col_shared: assert property (@(posedge clk) disable iff (srst) // see (R2)
    meas_valid && min_ok |=> col_detect_reg == $past(col_pass))
    else $error("column detect does not follow ratio test");
  a_twist_blocks: assert property (@(posedge clk) disable iff (srst) // see (R3)
    meas_valid && (fwd_over || rev_over) |=> !key_valid_reg)
    else $error("twisted frame produced a key");
  a_rev_twist_blocks: assert property (@(posedge clk) disable iff (srst) // see (R4)
    meas_valid && rev_over |=> !key_valid_reg)
    else $error("reverse twisted frame produced a key");
  a_dom_blocks: assert property (@(posedge clk) disable iff (srst) // see (R5) (R6)
    meas_valid && !(chk.low_dom_ok && chk.high_dom_ok) |=> !key_valid_reg)
    else $error("frame without dominance produced a key");
  a_harm_blocks: assert property (@(posedge clk) disable iff (srst) // see (R7) (R8)
    meas_valid && !(low_harm_ok && high_harm_ok) |=> !key_valid_reg)
    else $error("harmonic rich frame produced a key");
  a_agc_follow: assert property (@(posedge clk) disable iff (srst) // see (R10)
    meas_valid |=> agc_step_reg == $past(hot))
    else $error("gain step not tied to hot limit");
  a_agc_hold: assert property (@(posedge clk) disable iff (srst) // see (R10)
    !meas_valid |=> $stable(agc_step_reg))
    else $error("gain step moved between frames");
  a_key_code: assert property (@(posedge clk) disable iff (srst) // see (R16)
    key_valid_reg |-> row_detect_reg[key_code_reg[3:2]] && col_detect_reg[key_code_reg[1:0]])
    else $error("key code does not match detects");

endmodule

// *** hw/dtd_pkg.sv ***
package dtd_pkg;

  // Clock and indirect update timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned UPDATE_HZ     = 16_000;
  localparam int unsigned UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
  localparam int unsigned UPD_CNT_W     = 11;

  // Data widths
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned SUM_W   = 18;
  localparam int unsigned PROD_W  = 36;

  // Ratio codes that stand for exactly one
  localparam logic [15:0] PASS_UNITY = 16'h7FF0;
  localparam logic [15:0] REL_UNITY  = 16'h07F0;

  // Indirect register locations
  localparam int unsigned IND_DEPTH = 13;
  localparam logic [3:0] IDX_LOW_PASS_0   = 4'h0;
  localparam logic [3:0] IDX_HIGH_PASS    = 4'h4;
  localparam logic [3:0] IDX_FWD_TWIST    = 4'h5;
  localparam logic [3:0] IDX_REV_TWIST    = 4'h6;
  localparam logic [3:0] IDX_LOW_DOM      = 4'h7;
  localparam logic [3:0] IDX_HIGH_DOM     = 4'h8;
  localparam logic [3:0] IDX_LOW_HARM     = 4'h9;
  localparam logic [3:0] IDX_HIGH_HARM    = 4'hA;
  localparam logic [3:0] IDX_MIN_POWER    = 4'hB;
  localparam logic [3:0] IDX_AGC_HOT      = 4'hC;

  // Reset value of the visible data port
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Threshold image handed to the decision logic
  typedef logic [IND_DEPTH-1:0][WORD_W-1:0] dtd_thr_array_type;

  // Four band powers of one group
  typedef logic [3:0][WORD_W-1:0] dtd_pow4_type;

  // One frame of measured powers
  typedef struct packed {
    dtd_pow4_type      row_pow;
    dtd_pow4_type      col_pow;
    logic [WORD_W-1:0] row_harm;
    logic [WORD_W-1:0] col_harm;
  } dtd_meas_type;

  // Pass flags of each individual check
  typedef struct packed {
    logic fwd_twist_ok;
    logic rev_twist_ok;
    logic low_dom_ok;
    logic high_dom_ok;
    logic low_harm_ok;
    logic high_harm_ok;
    logic min_power_ok;
  } dtd_checks_type;

endpackage

// *** hw/dtd_ratio_cmp.sv ***
`timescale 1ns/10ps
// Signed ratio test: num/den above thr/UNITY, done by cross products
module dtd_ratio_cmp
  import dtd_pkg::*;
#(
  parameter logic [15:0] UNITY = PASS_UNITY
) (
  // Operands
  input  wire logic        [SUM_W-1:0]  num,
  input  wire logic        [SUM_W-1:0]  den,
  input  wire logic signed [WORD_W-1:0] thr,
  // Result
  output logic                          above
);

  logic signed [SUM_W:0]    num_s;    // Zero-extended numerator
  logic signed [SUM_W:0]    den_s;    // Zero-extended denominator
  logic signed [16:0]       unity_s;  // Unity code as signed
  logic signed [PROD_W-1:0] lhs;      // num times unity
  logic signed [PROD_W-1:0] rhs;      // thr times den

  // Threshold kept signed so a negative limit passes unless num and den are both zero
  assign num_s   = $signed({1'b0, num});
  assign den_s   = $signed({1'b0, den});
  assign unity_s = $signed({1'b0, UNITY});
  assign lhs     = PROD_W'(num_s * unity_s);
  assign rhs     = PROD_W'(thr * den_s);
  assign above   = lhs > rhs;

endmodule

// *** hw/dtd_indirect.sv ***
`timescale 1ns/10ps
// Indirect threshold store behind a data and an address port
module dtd_indirect
  import dtd_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Direct port writes
  input  wire logic              data_wr,
  input  wire logic [WORD_W-1:0] data_in,
  input  wire logic              addr_wr,
  input  wire logic [ADDR_W-1:0] addr_in,
  // Direct port state
  output logic      [WORD_W-1:0] data_port,
  output logic                   pending,
  output logic                   done,
  // Threshold image
  output dtd_thr_array_type      thr
);

  logic [WORD_W-1:0]    mem [IND_DEPTH];  // Threshold words, no reset
  logic [UPD_CNT_W-1:0] cnt_reg;          // Update rate divider
  logic                 tick_reg;         // One cycle per update slot
  logic                 armed_reg;        // Data written since last address
  logic                 op_wr_reg;        // Pending request is a write
  logic [ADDR_W-1:0]    addr_reg;         // Pending address
  logic                 pend_reg;         // Request outstanding
  logic                 done_reg;         // Completion pulse
  logic [WORD_W-1:0]    data_reg;         // Data port
  logic                 cnt_wrap;         // Divider end
  logic                 svc;              // Service this cycle
  logic                 addr_ok;          // Address inside the store
  logic                 pend_next;
  logic [WORD_W-1:0]    data_next;

  // Decode of the service slot
  assign cnt_wrap  = cnt_reg == UPD_CNT_W'(UPDATE_CYCLES - 1);
  assign svc       = tick_reg & pend_reg;                          // see (R15)
  assign addr_ok   = addr_reg < ADDR_W'(IND_DEPTH);
  // A new request in the service cycle keeps the flag set
  assign pend_next = addr_wr | (pend_reg & ~svc);                  // see (R15)
  // Software write wins over a read completion in the same cycle
  assign data_next = data_wr                   ? data_in :
                     (svc & ~op_wr_reg & addr_ok) ? mem[addr_reg[3:0]] :
                     (svc & ~op_wr_reg)        ? DATA_RESET : data_reg;

  // Update rate divider
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_wrap ? '0 : cnt_reg + 1'b1;
      tick_reg <= cnt_wrap;                                        // see (R15)
    end
  end

  // Request capture and completion
  always_ff @(posedge clk) begin
    if (srst) begin
      armed_reg <= 1'b0;
      op_wr_reg <= 1'b0;
      addr_reg  <= '0;
      pend_reg  <= 1'b0;
      done_reg  <= 1'b0;
      data_reg  <= DATA_RESET;
    end else begin
      armed_reg <= addr_wr ? 1'b0 : (armed_reg | data_wr);
      if (addr_wr) begin
        op_wr_reg <= armed_reg | data_wr;                          // see (R14)
        addr_reg  <= addr_in;
      end
      pend_reg  <= pend_next;
      done_reg  <= svc;                                            // see (R15)
      data_reg  <= data_next;                                      // see (R14)
    end
  end

  // Store write; contents stay undefined until programmed
  always_ff @(posedge clk) begin
    if (svc && op_wr_reg && addr_ok) begin
      mem[addr_reg[3:0]] <= data_reg;                              // see (R14)
    end
  end

  // Threshold image for the decision logic
  genvar gi;
  generate
    for (gi = 0; gi < IND_DEPTH; gi++) begin : g_thr
      assign thr[gi] = mem[gi];
    end
  endgenerate

  assign data_port = data_reg;
  assign pending   = pend_reg;
  assign done      = done_reg;

  a_pend_after_addr: assert property (@(posedge clk) disable iff (srst) // see (R15)
    addr_wr |=> pend_reg) else $error("address write did not raise pending");
  a_done_ends_pend: assert property (@(posedge clk) disable iff (srst) // see (R15)
    svc && !addr_wr |=> done_reg && !pend_reg) else $error("service did not complete");
  a_write_lands: assert property (@(posedge clk) disable iff (srst) // see (R14)
    svc && op_wr_reg && addr_ok |=> mem[$past(addr_reg[3:0])] == $past(data_reg))
    else $error("indirect write lost");
  a_tick_spacing: assert property (@(posedge clk) disable iff (srst) // see (R15)
    tick_reg |=> !tick_reg [*8]) else $error("update slots too close");

endmodule

// *** verif/testbench.sv ***
`timescale 1ns/10ps
module testbench
  import dtd_pkg::*;
;
  // Tuned thresholds that let clean key frames pass
  localparam logic [15:0] TUNED [IND_DEPTH] = '{16'h6000, 16'h6000, 16'h6000, 16'h6000,
    16'h6000, 16'h1FC0, 16'h1FC0, 16'h1FC0, 16'h1FC0, 16'h1FC0, 16'h1FC0, 16'h0400, 16'h7000};

  // Stimulus
  logic              clk;
  logic              srst;
  logic              data_wr;
  logic [WORD_W-1:0] data_in;
  logic              addr_wr;
  logic [ADDR_W-1:0] addr_in;
  logic              meas_valid;
  dtd_meas_type      meas;
  // Observed outputs
  logic [WORD_W-1:0] indirect_data_port;
  logic              indirect_pending_flag;
  logic              indirect_done_interrupt;
  logic              result_valid;
  logic [3:0]        row_detect;
  logic [3:0]        col_detect;
  dtd_checks_type    checks;
  logic              key_valid;
  logic [3:0]        key_code;
  logic              agc_step;
  // Bench state and expectations
  int                errors;
  int                cmp_count;
  logic [31:0]       seed;
  logic [WORD_W-1:0] thr_m [IND_DEPTH];
  logic [3:0]        exp_row;
  logic [3:0]        exp_col;
  dtd_checks_type    exp_chk;
  logic              exp_key;
  logic [3:0]        exp_code;
  logic              exp_agc;

  // Design under test
  dtd_thresholds DUT (
    .clk                     (clk),
    .srst                    (srst),
    .data_wr                 (data_wr),
    .data_in                 (data_in),
    .addr_wr                 (addr_wr),
    .addr_in                 (addr_in),
    .indirect_data_port      (indirect_data_port),
    .indirect_pending_flag   (indirect_pending_flag),
    .indirect_done_interrupt (indirect_done_interrupt),
    .meas_valid              (meas_valid),
    .meas                    (meas),
    .result_valid            (result_valid),
    .row_detect              (row_detect),
    .col_detect              (col_detect),
    .checks                  (checks),
    .key_valid               (key_valid),
    .key_code                (key_code),
    .agc_step                (agc_step)
  );

  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Repeatable pseudo-random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Threshold as a signed number
  function automatic longint st(input int i);
    return longint'($signed(thr_m[i]));
  endfunction

  // Reference decision for one frame
  function automatic void model(input dtd_meas_type m);
    longint rp [4];
    longint cp [4];
    longint rt, ct, pr, pc, pu, ru;
    int     ri, ci;
    pu = PASS_UNITY;
    ru = REL_UNITY;
    rt = 0;
    ct = 0;
    ri = 0;
    ci = 0;
    for (int i = 0; i < 4; i++) begin
      rp[i] = m.row_pow[i];
      cp[i] = m.col_pow[i];
      rt += rp[i];
      ct += cp[i];
      if (rp[i] > rp[ri]) ri = i;
      if (cp[i] > cp[ci]) ci = i;
    end
    pr = rp[ri];
    pc = cp[ci];
    exp_chk.fwd_twist_ok = !(pr * ru > st(5) * pc);
    exp_chk.rev_twist_ok = !(pc * ru > st(6) * pr);
    exp_chk.low_dom_ok   = 1'b1;
    exp_chk.high_dom_ok  = 1'b1;
    for (int i = 0; i < 4; i++) begin
      exp_row[i] = rp[i] * pu > st(i) * rt;
      exp_col[i] = cp[i] * pu > st(4) * ct;
      if (i != ri && !(pr * ru > st(7) * rp[i])) exp_chk.low_dom_ok = 1'b0;
      if (i != ci && !(pc * ru > st(8) * cp[i])) exp_chk.high_dom_ok = 1'b0;
    end
    exp_chk.low_harm_ok  = pr * ru > st(9) * longint'(m.row_harm);
    exp_chk.high_harm_ok = pc * ru > st(10) * longint'(m.col_harm);
    exp_chk.min_power_ok = rt + ct >= st(11);
    exp_agc = rt + ct > st(12);
    // Gate clears detections but still reports checks
    if (!exp_chk.min_power_ok) begin
      exp_row = 4'h0;
      exp_col = 4'h0;
    end
    exp_key  = $countones(exp_row) == 1 && $countones(exp_col) == 1 && (&exp_chk);
    exp_code = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (exp_key && exp_row[i]) exp_code[3:2] = 2'(i);
      if (exp_key && exp_col[i]) exp_code[1:0] = 2'(i);
    end
  endfunction

  // One counted comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Indirect write or read, waiting for the service slot
  task automatic ind_req(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [WORD_W-1:0] d);
    int n;
    @(posedge clk) #1;
    if (wr) begin
      data_wr = 1'b1;
      data_in = d;
      @(posedge clk) #1;
      data_wr = 1'b0;
      chk("data_port_latched", 32'(d), 32'(indirect_data_port));
    end
    addr_wr = 1'b1;
    addr_in = a;
    @(posedge clk) #1;
    addr_wr = 1'b0;
    chk("pending_set", 32'h0000_0001, 32'(indirect_pending_flag));
    n = 0;
    while (indirect_done_interrupt !== 1'b1 && n < 1600) begin
      @(posedge clk) #1;
      n++;
    end
    chk("service_in_slot", 32'h0000_0001, 32'(n <= 1562));
    chk("pending_cleared", 32'h0000_0000, 32'(indirect_pending_flag));
    if (!wr) chk("read_data", 32'(d), 32'(indirect_data_port));
  endtask

  // One measurement frame and its decision
  task automatic frame(input dtd_meas_type m);
    @(posedge clk) #1;
    meas_valid = 1'b1;
    meas       = m;
    model(m);
    @(posedge clk) #1;
    meas_valid = 1'b0;
    chk("result_valid", 32'h0000_0001, 32'(result_valid));
    chk("row_detect", 32'(exp_row), 32'(row_detect));
    chk("col_detect", 32'(exp_col), 32'(col_detect));
    chk("checks", 32'(exp_chk), 32'(checks));
    chk("key_valid", 32'(exp_key), 32'(key_valid));
    chk("key_code", 32'(exp_code), 32'(key_code));
    chk("agc_step", 32'(exp_agc), 32'(agc_step));
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog sized for about 41 indirect requests plus frames
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    dtd_meas_type m;
    logic [31:0]  r;
    srst = 1'b1; data_wr = 1'b0; data_in = '0; addr_wr = 1'b0;
    addr_in = '0; meas_valid = 1'b0; meas = '0;
    errors = 0; cmp_count = 0; seed = 32'h0000_a0f0;
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    chk("data_port_reset", 32'h0000_0000, 32'(indirect_data_port));
    chk("pending_reset", 32'h0000_0000, 32'(indirect_pending_flag));
    // Random words, sign bit included, programmed then read back
    for (int i = 0; i < IND_DEPTH; i++) begin
      thr_m[i] = 16'(xs());
      ind_req(1'b1, 8'(i), thr_m[i]);
    end
    for (int i = 0; i < IND_DEPTH; i++) ind_req(1'b0, 8'(i), thr_m[i]);
    // Store has only thirteen words
    ind_req(1'b1, 8'h0d, 16'h5a5a);
    ind_req(1'b0, 8'h0d, 16'h0000);
    // Random frames, row 2 and row 3 powers left zero, against signed random thresholds
    for (int k = 0; k < 150; k++) begin
      m = {xs(), xs(), xs(), xs()};
      frame(m);
    end
    // Tuned thresholds, then key-like frames
    for (int i = 0; i < IND_DEPTH; i++) begin
      thr_m[i] = TUNED[i];
      ind_req(1'b1, 8'(i), thr_m[i]);
    end
    for (int k = 0; k < 200; k++) begin
      for (int i = 0; i < 4; i++) begin
        r = xs();
        m.row_pow[i] = {8'h00, r[7:0]};
        m.col_pow[i] = {8'h00, r[15:8]};
      end
      r = xs();
      m.row_pow[r[1:0]] = {3'h1, r[12:0]};
      m.col_pow[r[3:2]] = {3'h1, r[28:16]};
      m.row_harm = r[29] ? 16'h4000 : {10'h000, r[9:4]};
      m.col_harm = r[30] ? 16'h4000 : {10'h000, r[15:10]};
      frame(m);
    end
    // Power gate boundary and a row tie
    for (int g = 0; g < 3; g++) begin
      m = '0;
      m.row_pow[1] = 16'h0200;
      m.col_pow[2] = (g == 1) ? 16'h01ff : 16'h0200;
      if (g == 2) m.row_pow[0] = 16'h0200;
      frame(m);
    end
    end_of_test();
  end
endmodule
